// File: hdl/fer_defines.svh
`ifndef FER_DEFINES_SVH
`define FER_DEFINES_SVH

// ----------------------------------------
// field positions of the extended read register
// ----------------------------------------
`define FER_BIT_WIP 0
`define FER_BIT_PROT 1
`define FER_BIT_PERR 2
`define FER_BIT_EERR 3
`define FER_BIT_DLP 4
`define FER_DRV_LSB 5
`define FER_DRV_MSB 7
`define FER_WR_LSB 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define FER_RST_WRITABLE 4'he
`define FER_RST_DRIVE 3'h7

// ----------------------------------------
// drive strength codes
// ----------------------------------------
`define FER_DRV_RSVD_A 3'h0
`define FER_DRV_RSVD_B 3'h4

// ----------------------------------------
// opcodes on the serial link
// ----------------------------------------
`define FER_OP_SET_NV 8'h85
`define FER_OP_SET_V 8'h83
`define FER_OP_READ 8'h81
`define FER_OP_CLEAR 8'h82

`endif

// File: hdl/fer_pkg.sv
`default_nettype none

package fer_pkg;

	// kind of finished array or register operation reported by the engine
	typedef enum logic [3:0] {
		FER_OP_NONE = 4'h0,
		FER_OP_PAGE_PROG = 4'h1,
		FER_OP_LOCKBIT_PROG = 4'h2,
		FER_OP_PWD_PROG = 4'h3,
		FER_OP_INFO_PROG = 4'h4,
		FER_OP_MODE_PROG = 4'h5,
		FER_OP_UNLOCK = 4'h6,
		FER_OP_STATUS_WRITE = 4'h7,
		FER_OP_FUNC_WRITE = 4'h8,
		FER_OP_ERASE = 4'h9,
		FER_OP_CHIP_ERASE = 4'ha,
		FER_OP_REG_ERASE = 4'hb,
		FER_OP_REG_PROG = 4'hc
	} fer_op_t;

	typedef enum logic [2:0] {
		FER_NV_IDLE = 3'b001,
		FER_NV_ERASE = 3'b010,
		FER_NV_PROG = 3'b100
	} fer_nv_state_t;

endpackage

`default_nettype wire

// File: hdl/fer_link_if.sv
`timescale 1ns/10ps
`default_nettype none

interface fer_link_if;
	logic cmdTog;
	logic [7:0] cmdOp;
	logic [7:0] cmdData;
	logic pubTog;
	logic [7:0] pubWord;
	logic pubAck;

	modport link (output cmdTog, output cmdOp, output cmdData, input pubTog, input pubWord, output pubAck);
	modport core (input cmdTog, input cmdOp, input cmdData, output pubTog, output pubWord, input pubAck);
endinterface

`default_nettype wire

// File: hdl/fer_serial_link.sv
`timescale 1ns/10ps
`default_nettype none
`include "fer_defines.svh"

module fer_serial_link (
	input wire logic sck,
	input wire logic csN,
	input wire logic resetn,
	input wire logic si,
	output logic soOut,
	output logic soOeN,
	fer_link_if.link lnk
);
	logic [2:0] bitCnt_ff;
	logic [1:0] phase_ff;
	logic [6:0] shift_ff;
	logic [7:0] op_ff;
	logic [7:0] rxByte;
	logic cmdTog_ff;
	logic [7:0] cmdOp_ff;
	logic [7:0] cmdData_ff;
	logic pubMeta_ff;
	logic pubSync_ff;
	logic pubSeen_ff;
	logic [7:0] rdWord_ff;
	logic rdActive_ff;
	logic so_ff;

	assign rxByte = {shift_ff, si};

	// ----------------------------------------
	// frame state, cleared whenever chip select rises
	// ----------------------------------------
	always_ff @(posedge sck or posedge csN) begin
		if (csN) begin
			bitCnt_ff <= 3'h0;
			phase_ff <= 2'h0;
			shift_ff <= 7'h00;
			op_ff <= 8'h00;
		end else begin
			bitCnt_ff <= bitCnt_ff + 3'h1;
			shift_ff <= rxByte[6:0];
			if (bitCnt_ff == 3'h7 && phase_ff != 2'h2) begin
				phase_ff <= phase_ff + 2'h1;
				if (phase_ff == 2'h0) begin
					op_ff <= rxByte;
				end
			end
		end
	end

	// ----------------------------------------
	// commands handed to the core: data held, toggle marks a new one
	// ----------------------------------------
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			cmdTog_ff <= 1'b0;
			cmdOp_ff <= 8'h00;
			cmdData_ff <= 8'h00;
		end else if (!csN && bitCnt_ff == 3'h7) begin
			if (phase_ff == 2'h0 && rxByte == `FER_OP_CLEAR) begin
				cmdOp_ff <= rxByte;
				cmdTog_ff <= ~cmdTog_ff;
			end else if (phase_ff == 2'h1 && (op_ff == `FER_OP_SET_NV || op_ff == `FER_OP_SET_V)) begin
				cmdOp_ff <= op_ff;
				cmdData_ff <= rxByte;
				cmdTog_ff <= ~cmdTog_ff;
			end
		end
	end

	// ----------------------------------------
	// register snapshot published by the core
	// ----------------------------------------
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			pubMeta_ff <= 1'b0;
			pubSync_ff <= 1'b0;
			pubSeen_ff <= 1'b0;
			rdWord_ff <= 8'h00;
		end else begin
			pubMeta_ff <= lnk.pubTog;
			pubSync_ff <= pubMeta_ff;
			// the snapshot only moves before the data phase, so a read never mixes two words
			if (pubSync_ff != pubSeen_ff && phase_ff == 2'h0) begin
				pubSeen_ff <= pubSync_ff;
				rdWord_ff <= lnk.pubWord;
			end
		end
	end

	// ----------------------------------------
	// read data shifted out on the falling edge, msb first, repeating
	// ----------------------------------------
	always_ff @(negedge sck or posedge csN) begin
		if (csN) begin
			so_ff <= 1'b0;
			rdActive_ff <= 1'b0;
		end else begin
			rdActive_ff <= phase_ff != 2'h0 && op_ff == `FER_OP_READ;
			so_ff <= rdWord_ff[3'h7 - bitCnt_ff];
		end
	end

	assign soOut = so_ff;
	assign soOeN = csN | ~rdActive_ff;
	assign lnk.cmdTog = cmdTog_ff;
	assign lnk.cmdOp = cmdOp_ff;
	assign lnk.cmdData = cmdData_ff;
	assign lnk.pubAck = pubSeen_ff;
endmodule

`default_nettype wire

// File: hdl/fer_ext_read_reg.sv
// Function
// - bits 7:5 select output drive impedance
// - bits 3:0 untouched by set commands
// - 85h writes nonvolatile, 83h writes volatile copy
// - bit 0 mirrors status write in progress
// - protection error on protected or locked access
// - program error on program or register-program failure
// - erase error on erase or register-erase failure
// - program failures; protected target sets both
// - locked info row program sets both flags
// - lock bits reprogram or both zero: both
// - wrong unlock password sets program and protection
// - register update: erase then program, flags separately
// - locked status write sets protection and erase
// - erase failures; protected target sets both
// - chip erase protection flag only for block protect
// - otp bits back to zero: ignored, silent
// - readonly or frozen bits discarded, silent
// - error flags sticky until clear command
// - hardware or software reset clears flags
// - error flags never block commands
`timescale 1ns/10ps
`default_nettype none
`include "fer_defines.svh"

module fer_ext_read_reg (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sck,
	input wire logic csN,
	input wire logic si,
	output logic soOut,
	output logic soOeN,
	input wire logic statusWip,
	input wire logic softReset,
	input wire logic opDone,
	input wire fer_pkg::fer_op_t opKind,
	input wire logic opFail,
	input wire logic protHit,
	input wire logic eraseSuspendHit,
	input wire logic blockProtectHit,
	input wire logic infoRowLocked,
	input wire logic modeAlreadySet,
	input wire logic lockBitsBothZero,
	input wire logic passwordMismatch,
	input wire logic statusWriteLocked,
	input wire logic otpRevertOnly,
	output logic nvEraseReq,
	input wire logic nvEraseDone,
	input wire logic nvEraseFail,
	output logic nvProgReq,
	input wire logic nvProgDone,
	input wire logic nvProgFail,
	output logic nvBusy,
	output logic [2:0] driveSel,
	output logic driveSelValid,
	output logic learningPatternEnable,
	output logic [7:0] extendedReadValue
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	fer_link_if lnk ();

	logic rstMeta_ff;
	logic rstSync_ff;
	logic rstN;
	logic cmdMeta_ff;
	logic cmdSync_ff;
	logic cmdSeen_ff;
	logic cmdEvent;
	logic setVolCmd;
	logic setNvCmd;
	logic clearCmd;
	logic ackMeta_ff;
	logic ackSync_ff;
	logic pubTog_ff;
	logic [7:0] pubWord_ff;
	logic [3:0] volBits_ff;
	logic [3:0] nvBits_ff;
	logic [3:0] nvPending_ff;
	logic reload_ff;
	fer_pkg::fer_nv_state_t nvState_ff;
	fer_pkg::fer_nv_state_t nxt_nvState;
	logic nvEraseErr;
	logic nvProgErr;
	logic [2:0] flagSet;
	logic [2:0] flagClr;
	logic [2:0] flags_ff;
	logic opPerr;
	logic opEerr;
	logic opProt;
	logic [7:0] regValue;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end

	assign rstN = rstSync_ff;

	// ----------------------------------------
	// link side on the serial clock
	// ----------------------------------------
	fer_serial_link u_link (
		.sck(sck),
		.csN(csN),
		.resetn(resetn),
		.si(si),
		.soOut(soOut),
		.soOeN(soOeN),
		.lnk(lnk.link)
	);

	// ----------------------------------------
	// command toggle crossing into the core clock
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cmdMeta_ff <= 1'b0;
			cmdSync_ff <= 1'b0;
			cmdSeen_ff <= 1'b0;
		end else begin
			cmdMeta_ff <= lnk.cmdTog;
			cmdSync_ff <= cmdMeta_ff;
			cmdSeen_ff <= cmdSync_ff;
		end
	end

	// decoding looks at the opcode only, never at the error flags
	assign cmdEvent = cmdSync_ff ^ cmdSeen_ff;
	assign setVolCmd = cmdEvent && lnk.cmdOp == `FER_OP_SET_V;
	assign setNvCmd = cmdEvent && lnk.cmdOp == `FER_OP_SET_NV;
	assign clearCmd = cmdEvent && lnk.cmdOp == `FER_OP_CLEAR;

	// ----------------------------------------
	// volatile copy of the writable bits
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			reload_ff <= 1'b1;
		end else begin
			reload_ff <= softReset;
		end
	end

	// only the upper nibble is taken, the status nibble of the data is dropped
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			volBits_ff <= `FER_RST_WRITABLE;
		end else if (reload_ff) begin
			volBits_ff <= nvBits_ff;
		end else if (setVolCmd) begin
			volBits_ff <= lnk.cmdData[7:`FER_WR_LSB];
		end
	end

	// ----------------------------------------
	// nonvolatile update: erase pass then program pass
	// ----------------------------------------
	always_comb begin
		nxt_nvState = nvState_ff;
		case (nvState_ff)
			fer_pkg::FER_NV_IDLE: begin
				if (setNvCmd) begin
					nxt_nvState = fer_pkg::FER_NV_ERASE;
				end
			end
			fer_pkg::FER_NV_ERASE: begin
				if (nvEraseDone) begin
					nxt_nvState = nvEraseFail ? fer_pkg::FER_NV_IDLE : fer_pkg::FER_NV_PROG;
				end
			end
			fer_pkg::FER_NV_PROG: begin
				if (nvProgDone) begin
					nxt_nvState = fer_pkg::FER_NV_IDLE;
				end
			end
			default: begin
				nxt_nvState = fer_pkg::FER_NV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			nvState_ff <= fer_pkg::FER_NV_IDLE;
		end else begin
			nvState_ff <= nxt_nvState;
		end
	end

	// a second set-nonvolatile command during an update is dropped
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			nvPending_ff <= `FER_RST_WRITABLE;
		end else if (setNvCmd && nvState_ff == fer_pkg::FER_NV_IDLE) begin
			nvPending_ff <= lnk.cmdData[7:`FER_WR_LSB];
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			nvBits_ff <= `FER_RST_WRITABLE;
		end else if (nvState_ff == fer_pkg::FER_NV_PROG && nvProgDone && !nvProgFail) begin
			nvBits_ff <= nvPending_ff;
		end
	end

	assign nvEraseReq = nvState_ff == fer_pkg::FER_NV_ERASE;
	assign nvProgReq = nvState_ff == fer_pkg::FER_NV_PROG;
	assign nvBusy = nvState_ff != fer_pkg::FER_NV_IDLE;
	assign nvEraseErr = nvState_ff == fer_pkg::FER_NV_ERASE && nvEraseDone && nvEraseFail;
	assign nvProgErr = nvState_ff == fer_pkg::FER_NV_PROG && nvProgDone && nvProgFail;

	// ----------------------------------------
	// error causes from finished operations
	// ----------------------------------------
	always_comb begin
		opPerr = 1'b0;
		opEerr = 1'b0;
		opProt = 1'b0;
		if (opDone) begin
			case (opKind)
				fer_pkg::FER_OP_PAGE_PROG, fer_pkg::FER_OP_LOCKBIT_PROG, fer_pkg::FER_OP_PWD_PROG: begin
					opProt = protHit | eraseSuspendHit;
					opPerr = opFail | opProt;
				end
				fer_pkg::FER_OP_INFO_PROG: begin
					opProt = infoRowLocked;
					opPerr = opFail | infoRowLocked;
				end
				fer_pkg::FER_OP_MODE_PROG: begin
					opProt = modeAlreadySet | lockBitsBothZero;
					opPerr = opFail | opProt;
				end
				fer_pkg::FER_OP_UNLOCK: begin
					opProt = passwordMismatch;
					opPerr = passwordMismatch;
				end
				fer_pkg::FER_OP_STATUS_WRITE: begin
					opProt = statusWriteLocked;
					opEerr = statusWriteLocked;
				end
				fer_pkg::FER_OP_FUNC_WRITE: begin
					// reverting one-time bits is not a failure by itself
					opPerr = opFail & ~otpRevertOnly;
				end
				fer_pkg::FER_OP_ERASE: begin
					opProt = protHit | infoRowLocked;
					opEerr = opFail | opProt;
				end
				fer_pkg::FER_OP_CHIP_ERASE: begin
					// sector locks alone do not count against a chip erase
					opProt = blockProtectHit;
					opEerr = opFail | blockProtectHit;
				end
				fer_pkg::FER_OP_REG_ERASE: begin
					opEerr = opFail;
				end
				fer_pkg::FER_OP_REG_PROG: begin
					opPerr = opFail;
				end
				default: begin
					opPerr = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// sticky error flags: erase, program, protection
	// ----------------------------------------
	assign flagSet[0] = opProt;
	assign flagSet[1] = opPerr | nvProgErr;
	assign flagSet[2] = opEerr | nvEraseErr;
	assign flagClr = {3{clearCmd | softReset}};

	// set wins over a clear in the same cycle
	generate
		for (genvar i = 0; i < 3; i++) begin : g_flag
			always_ff @(posedge clk or negedge rstN) begin
				if (!rstN) begin
					flags_ff[i] <= 1'b0;
				end else if (flagSet[i]) begin
					flags_ff[i] <= 1'b1;
				end else if (flagClr[i]) begin
					flags_ff[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// register image
	// ----------------------------------------
	always_comb begin
		regValue = 8'h00;
		regValue[`FER_DRV_MSB:`FER_BIT_DLP] = volBits_ff;
		regValue[`FER_BIT_EERR] = flags_ff[2];
		regValue[`FER_BIT_PERR] = flags_ff[1];
		regValue[`FER_BIT_PROT] = flags_ff[0];
		regValue[`FER_BIT_WIP] = statusWip;
	end

	// ----------------------------------------
	// publish the image to the link side, one word per handshake
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			ackMeta_ff <= 1'b0;
			ackSync_ff <= 1'b0;
		end else begin
			ackMeta_ff <= lnk.pubAck;
			ackSync_ff <= ackMeta_ff;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pubTog_ff <= 1'b0;
			pubWord_ff <= 8'h00;
		end else if (ackSync_ff == pubTog_ff && regValue != pubWord_ff) begin
			pubWord_ff <= regValue;
			pubTog_ff <= ~pubTog_ff;
		end
	end

	assign lnk.pubTog = pubTog_ff;
	assign lnk.pubWord = pubWord_ff;

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			driveSel <= `FER_RST_DRIVE;
			driveSelValid <= 1'b1;
			learningPatternEnable <= 1'b0;
			extendedReadValue <= 8'h00;
		end else begin
			driveSel <= regValue[`FER_DRV_MSB:`FER_DRV_LSB];
			driveSelValid <= regValue[`FER_DRV_MSB:`FER_DRV_LSB] != `FER_DRV_RSVD_A
				&& regValue[`FER_DRV_MSB:`FER_DRV_LSB] != `FER_DRV_RSVD_B;
			learningPatternEnable <= regValue[`FER_BIT_DLP];
			extendedReadValue <= regValue;
		end
	end
endmodule

`default_nettype wire

// File: testbench/fer_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module fer_host_model (
	output logic sck,
	output logic csN,
	output logic si,
	input wire logic soOut,
	input wire logic soOeN
);
	initial begin
		sck = 1'b0;
		csN = 1'b1;
		si = 1'b0;
	end

	// ----------------------------------------
	// one mode-0 frame; link clock stands still between frames
	// ----------------------------------------
	task automatic xfer(input logic [7:0] op, input logic [7:0] dat, input bit two, output logic [7:0] rd);
		logic [15:0] sh;
		int n;
		sh = {op, dat};
		n = two ? 16 : 8;
		rd = 8'h00;
		#7;
		csN = 1'b0;
		for (int i = 0; i < n; i++) begin
			si = sh[15 - i];
			#32;
			sck = 1'b1;
			if (i >= 8)
				rd = {rd[6:0], soOeN ? 1'bx : soOut};
			#32;
			sck = 1'b0;
		end
		#32;
		csN = 1'b1;
		si = ~si;
	endtask
endmodule

`default_nettype wire

// File: testbench/fer_ext_read_reg_props.sv
`timescale 1ns/10ps
`default_nettype none

module fer_ext_read_reg_props (
	input wire logic clk,
	input wire logic resetn,
	input wire logic csN,
	input wire logic softReset,
	input wire logic opDone,
	input wire fer_pkg::fer_op_t opKind,
	input wire logic protHit,
	input wire logic statusWip,
	input wire logic nvEraseReq,
	input wire logic nvEraseDone,
	input wire logic nvEraseFail,
	input wire logic nvProgReq,
	input wire logic nvProgDone,
	input wire logic nvProgFail,
	input wire logic [2:0] driveSel,
	input wire logic driveSelValid,
	input wire logic [7:0] extendedReadValue
);
	logic [3:0] sinceCs_ff;

	// ----------------------------------------
	// cycles since the last link frame
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sinceCs_ff <= 4'h0;
		else if (!csN)
			sinceCs_ff <= 4'h0;
		else if (sinceCs_ff != 4'hf)
			sinceCs_ff <= sinceCs_ff + 4'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_erase_ok;
		nvEraseReq && nvEraseDone && !nvEraseFail;
	endsequence
	sequence s_erase_bad;
		nvEraseReq && nvEraseDone && nvEraseFail;
	endsequence
	sequence s_prog_bad;
		nvProgReq && nvProgDone && nvProgFail;
	endsequence

	a_wip_busy_mirror: assert property (statusWip [*4] |-> extendedReadValue[0])
		else $error("busy not mirrored");
	a_wip_idle_mirror: assert property (!statusWip [*4] |-> !extendedReadValue[0])
		else $error("ready not mirrored");
	a_prot_prog_both: assert property (opDone && opKind == fer_pkg::FER_OP_PAGE_PROG && protHit
		|-> ##2 extendedReadValue[2:1] == 2'h3) else $error("protected program flags missing");
	a_flags_sticky: assert property ((|($past(extendedReadValue[3:1]) & ~extendedReadValue[3:1]))
		|-> sinceCs_ff < 4'ha || $past(softReset) || $past(softReset, 2) || $past(softReset, 3))
		else $error("error flag dropped without clear");
	a_soft_clears: assert property (softReset && !opDone |-> ##2 extendedReadValue[3:1] == 3'h0)
		else $error("soft reset left flags set");
	a_drive_valid: assert property (driveSelValid == !(driveSel == 3'h0 || driveSel == 3'h4))
		else $error("drive valid wrong");
	a_writable_quiet: assert property ($changed(extendedReadValue[7:4])
		|-> sinceCs_ff < 4'ha || $past(softReset, 3)) else $error("writable bits moved without a command");
	a_erase_then_prog: assert property (s_erase_ok |=> nvProgReq && !nvEraseReq)
		else $error("program pass did not follow erase");
	a_erase_fail_stop: assert property (s_erase_bad |=> !nvProgReq ##1 extendedReadValue[3])
		else $error("erase failure not flagged");
	a_prog_fail_flag: assert property (s_prog_bad |-> ##2 extendedReadValue[2])
		else $error("program failure not flagged");
	a_prog_has_erase: assert property ($rose(nvProgReq) |-> $past(nvEraseReq))
		else $error("program pass without erase");
endmodule

bind fer_ext_read_reg fer_ext_read_reg_props chk (.clk(clk), .resetn(resetn), .csN(csN), .softReset(softReset),
	.opDone(opDone), .opKind(opKind), .protHit(protHit), .statusWip(statusWip), .nvEraseReq(nvEraseReq),
	.nvEraseDone(nvEraseDone), .nvEraseFail(nvEraseFail), .nvProgReq(nvProgReq), .nvProgDone(nvProgDone),
	.nvProgFail(nvProgFail), .driveSel(driveSel), .driveSelValid(driveSelValid),
	.extendedReadValue(extendedReadValue));

`default_nettype wire

// File: testbench/fer_ext_read_reg_tb.sv
`timescale 1ns/10ps
`default_nettype none

module fer_ext_read_reg_tb;
	logic clk, resetn, sck, csN, si, soOut, soOeN, statusWip, softReset, opDone;
	fer_pkg::fer_op_t opKind;
	logic [9:0] qual;
	logic nvEraseReq, nvEraseDone, nvEraseFail, nvProgReq, nvProgDone, nvProgFail, nvBusy;
	logic [2:0] driveSel;
	logic driveSelValid, learningPatternEnable;
	logic [7:0] extendedReadValue, rd;
	int fail_count, comparisons;

	fer_ext_read_reg dut (.clk(clk), .resetn(resetn), .sck(sck), .csN(csN), .si(si), .soOut(soOut),
		.soOeN(soOeN), .statusWip(statusWip), .softReset(softReset), .opDone(opDone), .opKind(opKind),
		.opFail(qual[9]), .protHit(qual[8]), .eraseSuspendHit(qual[7]), .blockProtectHit(qual[6]),
		.infoRowLocked(qual[5]), .modeAlreadySet(qual[4]), .lockBitsBothZero(qual[3]),
		.passwordMismatch(qual[2]), .statusWriteLocked(qual[1]), .otpRevertOnly(qual[0]),
		.nvEraseReq(nvEraseReq), .nvEraseDone(nvEraseDone), .nvEraseFail(nvEraseFail),
		.nvProgReq(nvProgReq), .nvProgDone(nvProgDone), .nvProgFail(nvProgFail), .nvBusy(nvBusy),
		.driveSel(driveSel), .driveSelValid(driveSelValid), .learningPatternEnable(learningPatternEnable),
		.extendedReadValue(extendedReadValue));

	fer_host_model host (.sck(sck), .csN(csN), .si(si), .soOut(soOut), .soOeN(soOeN));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [7:0] op, input logic [7:0] d);
		host.xfer(op, d, op != 8'h82, rd);
		tick(8);
	endtask

	// first frame lets a pending snapshot land, the second one carries it
	task automatic rdReg();
		host.xfer(8'h81, 8'h00, 1'b1, rd);
		host.xfer(8'h81, 8'h00, 1'b1, rd);
	endtask

	task automatic fire(input fer_pkg::fer_op_t k, input logic [9:0] q);
		opDone = 1'b1;
		opKind = k;
		qual = q;
		tick(1);
		opDone = 1'b0;
		qual = 10'h000;
		tick(3);
	endtask

	// flags set, a later write still runs and keeps them, clear drops only them
	task automatic ev(input fer_pkg::fer_op_t k, input logic [9:0] q, input logic [2:0] e);
		fire(k, q);
		wr(8'h83, 8'hb0);
		check(extendedReadValue, {4'hb, e, 1'b0});
		wr(8'h82, 8'h00);
		check(extendedReadValue, 8'hb0);
	endtask

	task automatic nvStep(input bit prog, input logic bad);
		int n;
		n = 0;
		while ((prog ? nvProgReq : nvEraseReq) !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		if (n == 50) begin
			fail_count++;
			test_done();
		end
		{nvProgDone, nvProgFail} = prog ? {1'b1, bad} : 2'h0;
		{nvEraseDone, nvEraseFail} = prog ? 2'h0 : {1'b1, bad};
		tick(1);
		{nvEraseDone, nvEraseFail, nvProgDone, nvProgFail} = 4'h0;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{resetn, statusWip, softReset, opDone, nvEraseDone, nvEraseFail, nvProgDone, nvProgFail} = 8'h00;
		opKind = fer_pkg::FER_OP_NONE;
		qual = 10'h000;
		fail_count = 0;
		comparisons = 0;
		tick(12);
		resetn = 1'b1;
		tick(6);
		check(extendedReadValue, 8'he0);
		rdReg();
		check(rd, 8'he0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			wr(8'h83, {i[2:0], i[0], 4'hf});
			check(extendedReadValue, {i[2:0], i[0], 4'h0});
			check({5'h00, driveSel}, {5'h00, i[2:0]});
			check({7'h00, learningPatternEnable}, {7'h00, i[0]});
			check({7'h00, driveSelValid}, {7'h00, i != 0 && i != 4});
		end
		$display("test volatile write done");
		statusWip = 1'b1;
		tick(4);
		check(extendedReadValue, 8'hf1);
		rdReg();
		check(rd, 8'hf1);
		statusWip = 1'b0;
		tick(4);
		$display("test busy mirror done");
		ev(fer_pkg::FER_OP_PAGE_PROG, 10'h200, 3'h2);
		ev(fer_pkg::FER_OP_PAGE_PROG, 10'h100, 3'h3);
		ev(fer_pkg::FER_OP_PAGE_PROG, 10'h080, 3'h3);
		ev(fer_pkg::FER_OP_PWD_PROG, 10'h200, 3'h2);
		ev(fer_pkg::FER_OP_INFO_PROG, 10'h020, 3'h3);
		ev(fer_pkg::FER_OP_INFO_PROG, 10'h200, 3'h2);
		ev(fer_pkg::FER_OP_MODE_PROG, 10'h010, 3'h3);
		ev(fer_pkg::FER_OP_MODE_PROG, 10'h008, 3'h3);
		ev(fer_pkg::FER_OP_UNLOCK, 10'h004, 3'h3);
		ev(fer_pkg::FER_OP_STATUS_WRITE, 10'h002, 3'h5);
		ev(fer_pkg::FER_OP_FUNC_WRITE, 10'h201, 3'h0);
		ev(fer_pkg::FER_OP_FUNC_WRITE, 10'h200, 3'h2);
		ev(fer_pkg::FER_OP_ERASE, 10'h200, 3'h4);
		ev(fer_pkg::FER_OP_ERASE, 10'h100, 3'h5);
		ev(fer_pkg::FER_OP_CHIP_ERASE, 10'h040, 3'h5);
		ev(fer_pkg::FER_OP_CHIP_ERASE, 10'h100, 3'h0);
		ev(fer_pkg::FER_OP_LOCKBIT_PROG, 10'h100, 3'h3);
		ev(fer_pkg::FER_OP_REG_ERASE, 10'h200, 3'h4);
		ev(fer_pkg::FER_OP_REG_PROG, 10'h200, 3'h2);
		ev(fer_pkg::FER_OP_NONE, 10'h3ff, 3'h0);
		$display("test error flags done");
		fire(fer_pkg::FER_OP_ERASE, 10'h200);
		softReset = 1'b1;
		tick(1);
		softReset = 1'b0;
		tick(3);
		check(extendedReadValue, 8'he0);
		$display("test soft reset done");
		wr(8'h85, 8'h5f);
		nvStep(1'b0, 1'b0);
		nvStep(1'b1, 1'b0);
		tick(3);
		check(extendedReadValue, 8'he0);
		softReset = 1'b1;
		tick(1);
		softReset = 1'b0;
		tick(3);
		check(extendedReadValue, 8'h50);
		wr(8'h85, 8'h3f);
		nvStep(1'b0, 1'b1);
		tick(3);
		check(extendedReadValue, 8'h58);
		check({7'h00, nvBusy}, 8'h00);
		wr(8'h82, 8'h00);
		wr(8'h85, 8'h3f);
		nvStep(1'b0, 1'b0);
		nvStep(1'b1, 1'b1);
		tick(3);
		check(extendedReadValue, 8'h54);
		$display("test nonvolatile update done");
		fire(fer_pkg::FER_OP_ERASE, 10'h200);
		resetn = 1'b0;
		tick(3);
		check(extendedReadValue, 8'h00);
		resetn = 1'b1;
		tick(6);
		check(extendedReadValue, 8'he0);
		$display("test hardware reset done");
		test_done();
	end
endmodule

`default_nettype wire
